// file: rtl/nand_host_pkg.sv
// Package for the NAND flash host controller: constants, pin bundle, bus operation codes
package nand_host_pkg;
   localparam logic [7:0] CMD_READ_SETUP = 8'h00;
   localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
   localparam int ADDR_CYCLES = 5;
   localparam int BLOCK_COUNT = 4096;
   localparam int PAGES_PER_BLOCK = 64;
   localparam int MAIN_BYTES = 2048;
   localparam int SPARE_BYTES = 64;
   localparam int PAGE_BYTES = MAIN_BYTES + SPARE_BYTES;
   localparam int PAGE_WORDS = PAGE_BYTES / 2;
   localparam int COL_BITS_X8 = 12;
   localparam int COL_BITS_X16 = 11;
   localparam int ROW_BITS = 18;
   localparam int PLANE_ROW_BIT = 6;
   localparam int CLK_PERIOD_NS = 20;
   localparam int STROBE_LOW_NS = 40;
   localparam int STROBE_HIGH_NS = 40;
   localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] STROBE_LOW_CNT = CNT_W'(STROBE_LOW_CYC - 1);
   localparam logic [CNT_W-1:0] STROBE_HIGH_CNT = CNT_W'(STROBE_HIGH_CYC - 1);

   typedef struct packed {
      logic chipSelectN;
      logic cmdLatch;
      logic addrLatch;
      logic writeStrobeN;
      logic readStrobeN;
      logic writeGuardN;
   } pins_t;

   localparam pins_t PINS_IDLE = '{chipSelectN: 1'b1, cmdLatch: 1'b0, addrLatch: 1'b0,
                                   writeStrobeN: 1'b1, readStrobeN: 1'b1,
                                   writeGuardN: 1'b0};

   typedef enum logic [2:0] {
      BUS_CMD = 3'h0,
      BUS_ADDR = 3'h1,
      BUS_WDATA = 3'h2,
      BUS_RDATA = 3'h3
   } busop_t;
endpackage : nand_host_pkg

// file: rtl/nand_sync.sv
// Two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/10ps
module nand_sync #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk,            // System clock
   input wire logic resetn,             // Asynchronous reset, active low
   input wire logic clkEn,              // Clock enable
   input wire logic [WIDTH-1:0] asyncIn, // Pin levels
   output logic [WIDTH-1:0] syncOut     // Synchronised levels
);
   logic [WIDTH-1:0] stage1_q;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         stage1_q <= '0;
         syncOut <= '0;
      end else if (clkEn) begin
         stage1_q <= asyncIn;
         syncOut <= stage1_q;
      end
   end
endmodule : nand_sync

// file: rtl/nand_host.sv
// Host controller that drives a NAND flash through its strobe pins
`timescale 1ns/10ps
module nand_host #(
   parameter int WIDE = 0  // 1 for the 16-bit variant
) (
   input wire logic ref_clk,               // 50 MHz system clock
   input wire logic resetn,                // Asynchronous reset, active low
   input wire logic clkEn,                 // Freezes all state while low
   input wire logic reqValid,              // Page read request, one cycle
   input wire logic [11:0] reqColumn,      // Start column
   input wire logic [17:0] reqRow,         // Page row address
   input wire logic [15:0] reqCount,       // Bus reads to perform, at least 1
   input wire logic guardRelease,          // Level: allow program and erase
   output logic reqReady,                  // Idle, can take a request
   output logic dataValid,                 // Read data pulse
   output logic [15:0] dataOut,            // Read data
   output logic doneQ,                     // Request finished pulse
   output nand_host_pkg::pins_t pinsOut,   // Control pins
   output logic [15:0] ioOut,              // Bus drive value
   output logic ioOutEnN,                  // Bus output enable, low drives
   input wire logic [15:0] ioIn,           // Bus pin levels
   input wire logic readyBusyIn            // Pulled-up ready/busy pin level
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD1 = 3'b001,
      ST_ADDR = 3'b011,
      ST_CMD2 = 3'b010,
      ST_WAIT = 3'b110,
      ST_READ = 3'b111,
      ST_DONE = 3'b101
   } state_t;

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [16:0] syncBus;
   logic readySync;
   logic [15:0] ioSync;

   nand_sync #(.WIDTH(17)) u_sync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clkEn(clkEn),
      .asyncIn({readyBusyIn, ioIn}),
      .syncOut(syncBus)
   );
   assign readySync = syncBus[16];
   assign ioSync = syncBus[15:0];

   // ------------------------------------------------------------------
   // Address cycle layout
   // ------------------------------------------------------------------
   function automatic logic [7:0] addrByte(input logic [2:0] idx, input logic [11:0] col,
                                           input logic [17:0] row);
      logic [29:0] full;
      full = (WIDE != 0) ? {1'b0, row, col[10:0]} : {row, col};
      unique case (idx)
         3'h0: addrByte = full[7:0];
         3'h1: addrByte = (WIDE != 0) ? {5'h00, full[10:8]} : {4'h0, full[11:8]};
         3'h2: addrByte = (WIDE != 0) ? full[18:11] : full[19:12];
         3'h3: addrByte = (WIDE != 0) ? full[26:19] : full[27:20];
         default: addrByte = (WIDE != 0) ? {6'h00, full[28:27]} : {6'h00, full[29:28]};
      endcase
   endfunction : addrByte

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   localparam int CNT_W_L = nand_host_pkg::CNT_W;
   state_t state_q;
   logic [CNT_W_L-1:0] phase_q;
   logic strobeLow_q;
   logic [2:0] addrIdx_q;
   logic [11:0] col_q;
   logic [17:0] row_q;
   logic [15:0] remain_q;
   logic busySeen_q;
   logic phaseEnd;
   logic cycleEnd;

   assign phaseEnd = strobeLow_q ? (phase_q == nand_host_pkg::STROBE_LOW_CNT)
                                 : (phase_q == nand_host_pkg::STROBE_HIGH_CNT);
   assign cycleEnd = phaseEnd && !strobeLow_q;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         addrIdx_q <= 3'h0;
         col_q <= 12'h000;
         row_q <= 18'h00000;
         remain_q <= 16'h0000;
         busySeen_q <= 1'b0;
      end else if (clkEn) begin
         unique case (state_q)
            ST_IDLE: if (reqValid) begin
               col_q <= reqColumn;
               row_q <= reqRow;
               remain_q <= reqCount;
               addrIdx_q <= 3'h0;
               state_q <= ST_CMD1;
            end
            ST_CMD1: if (cycleEnd) state_q <= ST_ADDR;
            ST_ADDR: if (cycleEnd) begin
               addrIdx_q <= addrIdx_q + 3'h1;
               // Exactly five cycles; extras would be ignored anyway
               if (addrIdx_q == 3'(nand_host_pkg::ADDR_CYCLES - 1)) state_q <= ST_CMD2;
            end
            ST_CMD2: if (cycleEnd) begin
               busySeen_q <= 1'b0;
               state_q <= ST_WAIT;
            end
            ST_WAIT: begin
               // Busy may be short; allow for the synchroniser lag before trusting ready
               if (!readySync) busySeen_q <= 1'b1;
               if (readySync && busySeen_q) state_q <= ST_READ;
            end
            ST_READ: if (cycleEnd) begin
               remain_q <= remain_q - 16'h0001;
               if (remain_q <= 16'h0001) state_q <= ST_DONE;
            end
            ST_DONE: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Strobe phase timing
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         phase_q <= '0;
         strobeLow_q <= 1'b1;
      end else if (clkEn) begin
         // Armed low while parked, so every bus cycle opens with its low phase
         if (state_q == ST_IDLE || state_q == ST_WAIT || state_q == ST_DONE) begin
            phase_q <= '0;
            strobeLow_q <= 1'b1;
         end else if (phaseEnd) begin
            phase_q <= '0;
            strobeLow_q <= !strobeLow_q;
         end else begin
            phase_q <= phase_q + CNT_W_L'(1);
         end
      end
   end

   // ------------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pinsOut <= nand_host_pkg::PINS_IDLE;
         ioOut <= 16'h0000;
         ioOutEnN <= 1'b1;
      end else if (clkEn) begin
         pinsOut <= nand_host_pkg::PINS_IDLE;
         // Read-only sequencer: keep write guard low unless software opens it
         pinsOut.writeGuardN <= guardRelease;
         ioOutEnN <= 1'b1;
         ioOut <= 16'h0000;
         if (state_q != ST_IDLE && state_q != ST_DONE) pinsOut.chipSelectN <= 1'b0;
         unique case (state_q)
            ST_CMD1, ST_CMD2: begin
               pinsOut.cmdLatch <= 1'b1;
               pinsOut.writeStrobeN <= !strobeLow_q;
               ioOutEnN <= 1'b0;
               ioOut <= {8'h00, (state_q == ST_CMD1) ? nand_host_pkg::CMD_READ_SETUP
                                                     : nand_host_pkg::CMD_READ_CONFIRM};
            end
            ST_ADDR: begin
               pinsOut.addrLatch <= 1'b1;
               pinsOut.writeStrobeN <= !strobeLow_q;
               ioOutEnN <= 1'b0;
               ioOut <= {8'h00, addrByte(addrIdx_q, col_q, row_q)};
            end
            ST_READ: pinsOut.readStrobeN <= !strobeLow_q;
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Read data capture and status
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         dataValid <= 1'b0;
         dataOut <= 16'h0000;
         doneQ <= 1'b0;
         reqReady <= 1'b0;
      end else if (clkEn) begin
         // Sample as the cycle ends: the level seen one clock after the strobe
         // fell has only then come through both sync stages
         dataValid <= (state_q == ST_READ) && cycleEnd;
         if ((state_q == ST_READ) && cycleEnd)
            dataOut <= (WIDE != 0) ? ioSync : {8'h00, ioSync[7:0]};
         doneQ <= (state_q == ST_DONE);
         reqReady <= (state_q == ST_IDLE) && !reqValid;
      end
   end

   a_cs_released: assert property (@(posedge ref_clk) disable iff (!resetn)
      pinsOut.chipSelectN |-> ioOutEnN) else $error("bus driven with chip select high");
   a_read_no_drive: assert property (@(posedge ref_clk) disable iff (!resetn)
      !pinsOut.readStrobeN |-> ioOutEnN && !pinsOut.cmdLatch && !pinsOut.addrLatch)
      else $error("host drives bus during read");
   a_cmd_latch_data: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(pinsOut.writeStrobeN) && pinsOut.cmdLatch |-> !ioOutEnN)
      else $error("command strobe without data");
   a_addr_one_latch: assert property (@(posedge ref_clk) disable iff (!resetn)
      !(pinsOut.addrLatch && pinsOut.cmdLatch)) else $error("both latches high");
   a_wait_ready: assert property (@(posedge ref_clk) disable iff (!resetn)
      $fell(pinsOut.readStrobeN) |-> state_q == ST_READ) else $error("read before ready");
   a_strobe_write: assert property (@(posedge ref_clk) disable iff (!resetn)
      !pinsOut.writeStrobeN |-> !pinsOut.chipSelectN && pinsOut.readStrobeN)
      else $error("write strobe without select");
   a_addr_count: assert property (@(posedge ref_clk) disable iff (!resetn)
      state_q == ST_ADDR |-> addrIdx_q < 3'h5) else $error("too many address cycles");
   a_upper_low: assert property (@(posedge ref_clk) disable iff (!resetn)
      !ioOutEnN |-> ioOut[15:8] == 8'h00) else $error("upper byte not low");
endmodule : nand_host

// file: testbench/nand_dev_model.sv
// Behavioural flash device model facing the host controller
`timescale 1ns/10ps
module nand_dev_model (
   input wire logic ref_clk, // Times the array read
   input wire nand_host_pkg::pins_t pins, // Host control pins
   input wire logic [15:0] ioBus, // Resolved bus level
   input wire logic [15:0] busyCycles, // Array read length
   output logic devDrive, // Device drives the bus
   output logic [7:0] devOut, // Device bus value
   output logic busyPull, // Pulls ready/busy low
   output logic [11:0] capCol, // Column counter
   output logic [17:0] capRow, // Latched row
   output int nViol // Host protocol breaches
);
   logic [7:0] addrB [5];
   logic [7:0] lastCmd = 8'hff;
   int nAddr = 0;
   int busyCnt = 0;
   logic active;
   assign active = pins.chipSelectN === 1'b0;
   assign devDrive = active && !pins.readStrobeN && !pins.cmdLatch && !pins.addrLatch;
   assign devOut = capCol[7:0] ^ capRow[7:0] ^ 8'h5a;
   assign busyPull = busyCnt != 0;
   initial begin
      nViol = 0;
      capCol = 12'h000;
      capRow = 18'h00000;
   end
   // ---
   // Latching on the write strobe
   // ---
   always @(posedge pins.writeStrobeN) begin
      if (active && pins.cmdLatch) begin
         if (ioBus[7:0] == 8'h30) begin
            if (lastCmd != 8'h00 || nAddr < 5) nViol++;
            capCol = {addrB[1][3:0], addrB[0]};
            capRow = {addrB[4][1:0], addrB[3], addrB[2]};
            busyCnt = busyCycles;
         end
         if (ioBus[7:0] == 8'h00) nAddr = 0;
         lastCmd = ioBus[7:0];
      end else if (active && pins.addrLatch) begin
         if (nAddr == 1 && ioBus[7:4] != 4'h0) nViol++;
         if (nAddr == 4 && ioBus[7:2] != 6'h00) nViol++;
         if (nAddr < 5) addrB[nAddr] = ioBus[7:0];
         nAddr++;
      end
   end
   always @(negedge pins.readStrobeN) if (active && busyPull) nViol++;
   always @(posedge pins.readStrobeN) if (active) capCol++;
   always @(posedge ref_clk) if (busyCnt != 0) busyCnt--;
endmodule : nand_dev_model

// file: testbench/tb.sv
// Self-checking bench: host controller against the flash device model
`timescale 1ns/10ps
module tb;
   logic ref_clk = 1'b0, resetn = 1'b0, reqValid = 1'b0, guardRelease = 1'b0;
   logic [11:0] reqColumn = 12'h000, capCol;
   logic [17:0] reqRow = 18'h00000, capRow;
   logic [15:0] reqCount = 16'h0001, busyCycles = 16'h0005, lastBus = 16'h0000;
   logic [15:0] dataOut, ioOut, ioIn;
   logic reqReady, dataValid, doneQ, ioOutEnN, devDrive, busyPull;
   logic [7:0] devOut;
   nand_host_pkg::pins_t pinsOut;
   int nViol, n_mismatch = 0, n_compared = 0;
   // Released lines show the inverse of their last level, so stale data never passes
   assign ioIn = !ioOutEnN ? ioOut : devDrive ? {~lastBus[15:8], devOut} : ~lastBus;
   always @(posedge ref_clk) lastBus <= ioIn;
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   nand_host dut (.ref_clk(ref_clk), .resetn(resetn), .clkEn(1'b1), .reqValid(reqValid),
      .reqColumn(reqColumn), .reqRow(reqRow), .reqCount(reqCount),
      .guardRelease(guardRelease), .reqReady(reqReady), .dataValid(dataValid),
      .dataOut(dataOut), .doneQ(doneQ), .pinsOut(pinsOut), .ioOut(ioOut),
      .ioOutEnN(ioOutEnN), .ioIn(ioIn), .readyBusyIn(!busyPull));
   nand_dev_model dev (.ref_clk(ref_clk), .pins(pinsOut), .ioBus(ioIn),
      .busyCycles(busyCycles), .devDrive(devDrive), .devOut(devOut), .busyPull(busyPull),
      .capCol(capCol), .capRow(capRow), .nViol(nViol));
   always @(negedge ref_clk) begin
      if (devDrive === 1'b1 && ioOutEnN === 1'b0) check("contention", 1'b1, 1'b0);
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic stop_test();
      $display("Compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask : tick
   // ---
   // Page read with data and address checks
   // ---
   task automatic do_read(input logic [11:0] col, input logic [17:0] row,
         input logic [15:0] cnt, input logic [15:0] busy, input bit poke);
      int k;
      int got;
      logic [11:0] c;
      got = 0;
      c = col;
      busyCycles = busy;
      repeat (2) tick();
      check("idle", reqReady, 1'b1);
      reqColumn = col;
      reqRow = row;
      reqCount = cnt;
      reqValid = 1'b1;
      tick();
      reqValid = 1'b0;
      for (k = 0; k < 3000 && doneQ !== 1'b1; k++) begin
         if (dataValid === 1'b1) begin
            check("read data", dataOut[7:0], c[7:0] ^ row[7:0] ^ 8'h5a);
            c++;
            got++;
         end
         reqValid = poke && k == 60;
         if (poke && k == 60) check("ready in busy", reqReady, 1'b0);
         tick();
      end
      reqValid = 1'b0;
      if (k >= 3000) begin
         n_mismatch++;
         $display("Error done expected 1 seen 0");
         stop_test();
      end
      check("read count", got, cnt);
      check("row", capRow, row);
      check("column end", capCol, col + cnt[11:0]);
      check("host breaches", nViol, 0);
   endtask : do_read
   task automatic t_reset();
      check("reset pins", pinsOut, nand_host_pkg::PINS_IDLE);
      check("reset bus", ioOutEnN, 1'b1);
      resetn = 1'b1;
      repeat (2) tick();
      check("ready", reqReady, 1'b1);
      guardRelease = 1'b1;
      repeat (4) tick();
      check("guard off", pinsOut.writeGuardN, 1'b1);
      guardRelease = 1'b0;
      repeat (4) tick();
      check("guard on", pinsOut.writeGuardN, 1'b0);
      $display("Test reset done");
   endtask : t_reset
   task automatic t_abort();
      reqValid = 1'b1;
      tick();
      reqValid = 1'b0;
      repeat (12) tick();
      resetn = 1'b0;
      tick();
      check("abort pins", pinsOut, nand_host_pkg::PINS_IDLE);
      check("abort bus", ioOutEnN, 1'b1);
      resetn = 1'b1;
      do_read(12'h020, 18'h00456, 16'h0002, 16'h0005, 1'b0);
      $display("Test abort done");
   endtask : t_abort
   initial begin
      repeat (5) tick();
      t_reset();
      do_read(12'h004, 18'h00123, 16'h0004, 16'h0005, 1'b0);
      $display("Test short busy done");
      do_read(12'h83c, 18'h3ffff, 16'h0004, 16'h00c8, 1'b1);
      repeat (6) tick();
      check("no retake", pinsOut.chipSelectN, 1'b1);
      $display("Test long busy done");
      t_abort();
      stop_test();
   end
endmodule : tb
